// [core/fhc_engine.sv]
// flash high-speed crc engine: control, result and crc walk over code flash
// Behaviour
// - halt cpu, one flash word per clock
// - crc16 with x16+x12+x5+1 polynomial
// - shift each word bit 31 first
// - run only when halted from ram
// - enable bit 7 starts at next halt in main clock mode
// - range n up to 31 spans to (n+1)*16kb-8
// - control bit/byte writes, resets to 00
// - 16-bit result register, resets 0000
// - result writes need enable set
// - only code flash is read
`timescale 1ns/100ps
`default_nettype none
module fhc_engine #(
   parameter int WADDR_BITS = fhc_pkg::FHC_WADDR_BITS
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [19:0] sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [1:0]  sfr_size,
   input  wire logic [2:0]  sfr_bit,
   input  wire logic [15:0] sfr_wdata,
   output logic [15:0]      sfr_rdata,
   input  wire logic        halt_exec,
   input  wire logic        halt_from_ram,
   input  wire logic        main_clk_mode,
   output logic             cpu_stop,
   output logic             cpu_release,
   output logic             cflash_rd,
   output logic [WADDR_BITS-1:0] cflash_waddr,
   input  wire logic [31:0] cflash_rdata,
   output logic             busy
);
   // sfr_size: 0 = bit op, 1 = byte, 2 = word
   // ==========================================
   // registers
   logic [7:0]  control;
   logic [15:0] result;
   logic [15:0] crc;
   fhc_pkg::fhc_state_t state;
   logic [WADDR_BITS-1:0] last_waddr;
   logic [WADDR_BITS-1:0] fetch_addr;
   logic        fetch_last;
   logic        rd_pend;
   logic        rd_last;

   wire hit_ctl = (sfr_addr == fhc_pkg::FHC_ADDR_CONTROL);
   wire hit_res = (sfr_addr == fhc_pkg::FHC_ADDR_RESULT);
   wire enable  = control[fhc_pkg::FHC_ENABLE_BIT];
   wire [5:0] range_sel = control[fhc_pkg::FHC_RANGE_MSB:0];

   function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 31; i >= 0; i--) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? fhc_pkg::FHC_POLY : 16'h0000);
      end
      return r;
   endfunction : crc_word

   // ==========================================
   // register writes
   wire wr_ctl_bit  = sfr_wr & hit_ctl & (sfr_size == 2'd0);
   wire wr_ctl_byte = sfr_wr & hit_ctl & (sfr_size == 2'd1);
   wire [7:0] ctl_bit_val = (control & ~(8'h01 << sfr_bit))
                          | ({7'h00, sfr_wdata[0]} << sfr_bit);
   wire [7:0] ctl_wval = wr_ctl_byte ? sfr_wdata[7:0] : ctl_bit_val;
   // reserved bit 6 stays zero
   wire [7:0] next_control = {ctl_wval[7], 1'b0, ctl_wval[5:0]};
   wire wr_res = sfr_wr & hit_res & (sfr_size == 2'd2) & enable;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         control <= fhc_pkg::FHC_CONTROL_RST;
      end else if ((wr_ctl_bit || wr_ctl_byte) && state == fhc_pkg::FHC_IDLE) begin
         control <= next_control;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sfr_rdata <= 16'h0000;
      end else if (sfr_rd && hit_ctl) begin
         sfr_rdata <= {8'h00, control};
      end else if (sfr_rd && hit_res) begin
         sfr_rdata <= result;
      end else begin
         sfr_rdata <= 16'h0000;
      end
   end

   // ==========================================
   // engine sequencing
   wire start = (state == fhc_pkg::FHC_IDLE) & enable & halt_exec
              & halt_from_ram & main_clk_mode;
   wire [WADDR_BITS-1:0] span_last =
      WADDR_BITS'((32'(range_sel) + 32'd1) * 32'(fhc_pkg::FHC_BLOCK_WORDS) - 32'd2);

   fhc_pkg::fhc_word_t in_word;
   fhc_pkg::fhc_word_t out_word;
   logic in_ready;
   wire  issue = (state == fhc_pkg::FHC_RUN) & in_ready;
   wire  done_word = out_word.valid & out_word.last;

   // flash answers the cycle after the strobe, so its word is taken one cycle later
   assign in_word = {rd_pend, cflash_rdata, rd_last};

   fhc_skid u_skid (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .flush     (start),
      .in_word   (in_word),
      .in_ready  (in_ready),
      .out_word  (out_word),
      .out_ready (1'b1)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state        <= fhc_pkg::FHC_IDLE;
         cflash_waddr <= '0;
         fetch_addr   <= '0;
         last_waddr   <= '0;
         fetch_last   <= 1'b0;
         rd_pend      <= 1'b0;
         rd_last      <= 1'b0;
         crc          <= fhc_pkg::FHC_CRC_SEED;
      end else begin
         fetch_last <= issue & (fetch_addr == last_waddr);
         rd_pend    <= cflash_rd;
         rd_last    <= cflash_rd & fetch_last;
         case (state)
            fhc_pkg::FHC_IDLE: begin
               if (start) begin
                  state        <= fhc_pkg::FHC_RUN;
                  cflash_waddr <= '0;
                  fetch_addr   <= '0;
                  last_waddr   <= span_last;
                  crc          <= fhc_pkg::FHC_CRC_SEED;
               end
            end
            fhc_pkg::FHC_RUN: begin
               if (issue) begin
                  // address goes out together with its read strobe
                  cflash_waddr <= fetch_addr;
                  fetch_addr   <= fetch_addr + 1'b1;
                  if (fetch_addr == last_waddr) begin
                     state <= fhc_pkg::FHC_DRAIN;
                  end
               end
               if (out_word.valid) begin
                  crc <= crc_word(crc, out_word.data);
               end
            end
            fhc_pkg::FHC_DRAIN: begin
               if (out_word.valid) begin
                  crc <= crc_word(crc, out_word.data);
               end
               if (done_word) begin
                  state <= fhc_pkg::FHC_DONE;
               end
            end
            fhc_pkg::FHC_DONE: begin
               state <= fhc_pkg::FHC_IDLE;
            end
            default: begin
               state <= fhc_pkg::FHC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         result <= fhc_pkg::FHC_RESULT_RST;
      end else if (state == fhc_pkg::FHC_DONE) begin
         result <= crc;
      end else if (wr_res) begin
         result <= sfr_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpu_stop    <= 1'b0;
         cpu_release <= 1'b0;
         cflash_rd   <= 1'b0;
         busy        <= 1'b0;
      end else begin
         cpu_stop    <= start | (cpu_stop & ~(state == fhc_pkg::FHC_DONE));
         cpu_release <= (state == fhc_pkg::FHC_DONE);
         cflash_rd   <= issue;
         busy        <= start | (busy & ~(state == fhc_pkg::FHC_DONE));
      end
   end

   // ==========================================
   // checks
   a_idle_no_read: assert property (@(posedge clk_sys) disable iff (rst)
      (state == fhc_pkg::FHC_IDLE) |=> !cflash_rd)
      else $error("flash read outside a check");
   a_start_needs_enable: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(busy) |-> $past(enable) && $past(halt_from_ram))
      else $error("check started without enable or from flash");
   a_start_addr_zero: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(busy) |=> cflash_rd && cflash_waddr == '0)
      else $error("check does not start at address zero");
   a_word_per_clock: assert property (@(posedge clk_sys) disable iff (rst)
      cflash_rd && $past(cflash_rd) |-> cflash_waddr == $past(cflash_waddr) + 1'b1)
      else $error("flash address not stepping by one");
   a_span_end: assert property (@(posedge clk_sys) disable iff (rst)
      cflash_rd |-> cflash_waddr <= last_waddr)
      else $error("read beyond selected span");
   a_result_gated: assert property (@(posedge clk_sys) disable iff (rst)
      sfr_wr && hit_res && !enable && state != fhc_pkg::FHC_DONE |=> $stable(result))
      else $error("result written while disabled");
   a_result_done: assert property (@(posedge clk_sys) disable iff (rst)
      cpu_release |-> result == $past(crc))
      else $error("result not stored at release");
   a_release_stop: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(cpu_release) |-> ##1 !cpu_stop && !cpu_release)
      else $error("cpu not released after check");
   a_ctl_reserved: assert property (@(posedge clk_sys) disable iff (rst)
      wr_ctl_byte || wr_ctl_bit |=> control[6] == 1'b0)
      else $error("reserved control bit set");
   a_crc_msb: assert property (@(posedge clk_sys) disable iff (rst)
      out_word.valid && state == fhc_pkg::FHC_RUN
      |=> crc == crc_word($past(crc), $past(out_word.data)))
      else $error("crc step mismatch");
   c_full_check: cover property (@(posedge clk_sys) disable iff (rst) $rose(cpu_release));
   c_gated_write: cover property (@(posedge clk_sys) disable iff (rst) sfr_wr && hit_res && !enable);
   c_refused_halt: cover property (@(posedge clk_sys) disable iff (rst)
      halt_exec && enable && !halt_from_ram);
endmodule : fhc_engine
`default_nettype wire

// [core/fhc_pkg.sv]
// package for the flash high-speed crc engine
package fhc_pkg;
   // ==========================================
   // register map
   localparam logic [19:0] FHC_ADDR_CONTROL = 20'hF02F0;
   localparam logic [19:0] FHC_ADDR_RESULT  = 20'hF02F2;
   localparam logic [7:0]  FHC_CONTROL_RST  = 8'h00;
   localparam logic [15:0] FHC_RESULT_RST   = 16'h0000;
   localparam int          FHC_ENABLE_BIT   = 7;
   localparam int          FHC_RANGE_MSB    = 5;
   localparam logic [5:0]  FHC_RANGE_MAX    = 6'h1F;
   // ==========================================
   // crc and span
   localparam logic [15:0] FHC_POLY         = 16'h1021;
   localparam logic [15:0] FHC_CRC_SEED     = 16'h0000;
   localparam int          FHC_WORD_BITS    = 32;
   localparam int          FHC_BLOCK_WORDS  = 4096;
   localparam int          FHC_WADDR_BITS   = 17;
   // ==========================================
   // engine states, gray along idle-run-drain-done
   typedef enum logic [1:0] {
      FHC_IDLE  = 2'b00,
      FHC_RUN   = 2'b01,
      FHC_DRAIN = 2'b11,
      FHC_DONE  = 2'b10
   } fhc_state_t;
   typedef struct packed {
      logic        valid;
      logic [31:0] data;
      logic        last;
   } fhc_word_t;
endpackage : fhc_pkg

// [core/fhc_skid.sv]
// two-entry buffer between flash read data and the crc unit
`timescale 1ns/100ps
`default_nettype none
module fhc_skid (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               flush,
   input  wire fhc_pkg::fhc_word_t in_word,
   output logic                    in_ready,
   output fhc_pkg::fhc_word_t      out_word,
   input  wire logic               out_ready
);
   fhc_pkg::fhc_word_t slot [2];
   logic [1:0]         count;
   wire                push = in_word.valid & in_ready;
   wire                pop  = out_word.valid & out_ready;
   assign in_ready = (count != 2'd2);
   always_comb begin
      out_word       = slot[0];
      out_word.valid = (count != 2'd0);
   end
   always_ff @(posedge clk_sys) begin
      if (rst || flush) begin
         count <= 2'd0;
      end else begin
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
   always_ff @(posedge clk_sys) begin
      if (pop) begin
         slot[0] <= (count == 2'd2) ? slot[1] : in_word;
      end else if (push && count == 2'd0) begin
         slot[0] <= in_word;
      end
      if (push && ((count == 2'd1 && !pop) || (count == 2'd2))) begin
         slot[1] <= in_word;
      end
   end
endmodule : fhc_skid
`default_nettype wire

// [testbench/fhc_flash_model.sv]
// code flash model answering each word read on the following cycle
`timescale 1ns/100ps
`default_nettype none
module fhc_flash_model (
   input  wire logic        clk_sys,
   input  wire logic        cflash_rd,
   input  wire logic [16:0] cflash_waddr,
   output var  logic [31:0] cflash_rdata
);
   // ==========================================
   // word store
   // data is good for one cycle only, then the lines keep changing
   always @(posedge clk_sys) begin
      if (cflash_rd) begin
         cflash_rdata <= {cflash_waddr[15:0], ~cflash_waddr[15:0]} ^ 32'h5A3C_96E1;
      end else begin
         cflash_rdata <= ~cflash_rdata;
      end
   end
endmodule : fhc_flash_model
`default_nettype wire

// [testbench/flash_highspeed_crc_engine_test.sv]
// self-checking bench for the flash high-speed crc engine
`timescale 1ns/100ps
`default_nettype none
module flash_highspeed_crc_engine_test;
   localparam logic [19:0] ctl_a = fhc_pkg::FHC_ADDR_CONTROL;
   localparam logic [19:0] res_a = fhc_pkg::FHC_ADDR_RESULT;
   typedef struct packed {
      logic [19:0] a;
      logic [1:0]  s;
      logic [2:0]  b;
      logic [15:0] d;
      logic [15:0] e;
   } fhc_row_t;
   logic        clk_sys, rst, sfr_wr, sfr_rd, halt_exec, halt_from_ram, main_clk_mode;
   logic        cpu_stop, cpu_release, cflash_rd, busy;
   logic [19:0] sfr_addr;
   logic [1:0]  sfr_size;
   logic [2:0]  sfr_bit;
   logic [15:0] sfr_wdata, sfr_rdata, got;
   logic [16:0] cflash_waddr;
   logic [31:0] cflash_rdata;
   int          n_fail, comparisons, nrd;
   // address, size, bit, write data, value read back
   fhc_row_t rows [6] = '{
      '{ctl_a, 2'h1, 3'h0, 16'h00FF, 16'h00BF},
      '{ctl_a, 2'h0, 3'h3, 16'h0000, 16'h00B7},
      '{res_a, 2'h2, 3'h0, 16'h1234, 16'h1234},
      '{ctl_a, 2'h0, 3'h7, 16'h0000, 16'h0037},
      '{res_a, 2'h2, 3'h0, 16'hBEEF, 16'h1234},
      '{ctl_a, 2'h1, 3'h0, 16'h0000, 16'h0000}};

   fhc_engine fhc_engine_i (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_size(sfr_size), .sfr_bit(sfr_bit), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .halt_exec(halt_exec), .halt_from_ram(halt_from_ram),
      .main_clk_mode(main_clk_mode), .cpu_stop(cpu_stop), .cpu_release(cpu_release),
      .cflash_rd(cflash_rd), .cflash_waddr(cflash_waddr), .cflash_rdata(cflash_rdata),
      .busy(busy));
   fhc_flash_model fhc_flash_model_i (.clk_sys(clk_sys), .cflash_rd(cflash_rd),
      .cflash_waddr(cflash_waddr), .cflash_rdata(cflash_rdata));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ==========================================
   // helpers
   function automatic logic [31:0] pat(input logic [16:0] a);
      return {a[15:0], ~a[15:0]} ^ 32'h5A3C_96E1;
   endfunction : pat
   function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [31:0] w);
      for (int k = 31; k >= 0; k--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k]) ? fhc_pkg::FHC_POLY : 16'h0000);
      end
      return c;
   endfunction : crc_w
   task wrap_up;
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, seen);
         n_fail++;
      end
   endtask : check
   task automatic wr(input logic [19:0] a, input logic [1:0] s, input logic [2:0] b,
                     input logic [15:0] d);
      @(posedge clk_sys);
      sfr_addr  <= a;
      sfr_size  <= s;
      sfr_bit   <= b;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge clk_sys);
      sfr_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [19:0] a);
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge clk_sys);
      sfr_rd   <= 1'b0;
      #1 got = sfr_rdata;
   endtask : rd
   task automatic halt(input logic ram, input logic mclk);
      @(posedge clk_sys);
      halt_exec     <= 1'b1;
      halt_from_ram <= ram;
      main_clk_mode <= mclk;
      @(posedge clk_sys);
      halt_exec     <= 1'b0;
   endtask : halt
   task automatic idle_chk;
      repeat (6) begin
         @(posedge clk_sys);
         #1 check("no check started", {cpu_stop, busy, cflash_rd}, 0);
      end
   endtask : idle_chk
   task automatic run(input logic [5:0] n);
      logic [15:0] c;
      int          last, i;
      c    = fhc_pkg::FHC_CRC_SEED;
      last = (n + 1) * 4096 - 1;
      for (i = 0; i < last; i++) c = crc_w(c, pat(i[16:0]));
      wr(ctl_a, 2'h1, 3'h0, {8'h00, 2'b10, n});
      nrd = 0;
      halt(1'b1, 1'b1);
      // control write while running must not stick
      wr(ctl_a, 2'h1, 3'h0, 16'h0000);
      for (i = 0; i < 20000 && cpu_release !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      if (cpu_release !== 1'b1) begin
         n_fail++;
         wrap_up;
      end
      check("stop at release", {cpu_stop, busy}, 2'b00);
      check("words read", nrd, last);
      @(posedge clk_sys);
      #1 check("cpu released", {cpu_stop, busy}, 0);
      rd(res_a);
      check("crc result", got, c);
      rd(ctl_a);
      check("control kept", got, {8'h00, 2'b10, n});
   endtask : run

   // every word fetch is in order from zero while the cpu is held
   always @(posedge clk_sys) begin
      if (!rst && cflash_rd === 1'b1) begin
         check("flash address", cflash_waddr, nrd);
         check("cpu held", {busy, cpu_stop}, 2'b11);
         nrd <= nrd + 1;
      end
   end

   // ==========================================
   // main sequence
   initial begin
      {rst, sfr_wr, sfr_rd, halt_exec} = 4'hF & 4'h8;
      {halt_from_ram, main_clk_mode, sfr_size, sfr_bit} = 7'h00;
      sfr_addr  = 20'h00000;
      sfr_wdata = 16'h0000;
      n_fail = 0;
      comparisons = 0;
      nrd = 0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd(ctl_a);
      check("control reset", got, 16'h0000);
      rd(res_a);
      check("result reset", got, 16'h0000);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].s, rows[i].b, rows[i].d);
         rd(rows[i].a);
         check("register row", got, rows[i].e);
      end
      halt(1'b1, 1'b1);
      idle_chk;
      wr(ctl_a, 2'h1, 3'h0, 16'h0080);
      halt(1'b0, 1'b1);
      idle_chk;
      halt(1'b1, 1'b0);
      idle_chk;
      run(6'h00);
      run(6'h01);
      wrap_up;
   end
endmodule : flash_highspeed_crc_engine_test
`default_nettype wire
